// >>> verilog/rfcs_defs.vh
// Purpose: Register map, field positions and reset values of the converter
// Assumes: Word addressed plain register port, 8-bit address
// Notes:   Offsets are register indexes on the local port
`ifndef RFCS_DEFS_VH
`define RFCS_DEFS_VH
// ==========================================================================
// Register indexes
`define RFCS_ADDR_CTL   8'h00
`define RFCS_ADDR_TRG   8'h01
`define RFCS_ADDR_MC    8'h02
`define RFCS_ADDR_TC    8'h03
`define RFCS_ADDR_IMSK  8'h04
`define RFCS_ADDR_IFLG  8'h05
`define RFCS_ADDR_CLK   8'h06
// ==========================================================================
// Control register fields
`define RFCS_CTL_EN     0
`define RFCS_CTL_CHANNEL_SELECT  1
`define RFCS_CTL_MODE_L 4
`define RFCS_CTL_MODE_H 5
`define RFCS_CTL_EXT    6
`define RFCS_CTL_CONT   7
// Trigger register fields
`define RFCS_TRG_REF    0
`define RFCS_TRG_SA     1
`define RFCS_TRG_SB     2
// Flag and mask fields
`define RFCS_IF_REF     0
`define RFCS_IF_SA      1
`define RFCS_IF_SB      2
`define RFCS_IF_OVMC    3
`define RFCS_IF_OVTC    4
// Clock register fields
`define RFCS_CLK_EN     0
// ==========================================================================
// Reset values
`define RFCS_RST_CTL    8'h00
`define RFCS_RST_MASK   5'h00
`define RFCS_RST_CNT    24'h000000
`define RFCS_CNT_MAX    24'hffffff
`endif

// >>> verilog/rfcs_edge.v
// Purpose: Rising edge detector for a count clock sampled on CLK
// Assumes: Input already synchronous to clk
// Notes:   One-cycle pulse per rising edge
`timescale 1ns/100ps
`default_nettype none
module rfcs_edge (
  input  wire clk,
  input  wire rst_b,
  input  wire din,
  output wire rise
);
  reg din_r;
  always @(posedge clk) begin
    if (!rst_b) begin
      din_r <= 1'b0;
    end else begin
      din_r <= din;
    end
  end
  assign rise = din & ~din_r;
endmodule // rfcs_edge
`default_nettype wire

// >>> verilog/rfcs_cnt.v
// Purpose: 24-bit presettable up/down counter with wrap and zero pulses
// Assumes: Load has priority over counting
// Notes:   wrap pulses on an up count from all ones to zero
`timescale 1ns/100ps
`default_nettype none
`include "rfcs_defs.vh"
module rfcs_cnt #(
  parameter W = 24
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         step,
  input  wire         down,
  output reg  [W-1:0] cnt_r,
  output wire         wrap,
  output wire         hit_zero
);
  wire [W-1:0] all_ones = {W{1'b1}};
  wire [W-1:0] one      = {{(W-1){1'b0}}, 1'b1};
  assign wrap     = step & ~down & (cnt_r == all_ones);
  assign hit_zero = step & down & (cnt_r == one);
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= load_val;
    end else if (step) begin
      cnt_r <= down ? cnt_r - one : cnt_r + one;
    end
  end
endmodule // rfcs_cnt
`default_nettype wire

// >>> verilog/rfcs_top.v
// Purpose: Conversion sequencer and interrupt logic of an R/F converter
// Assumes: CR clocks and count clock are slow enough to sample on CLK
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// Contract
// - Only the selected channel oscillates; never both channels at once.
// - Channel select zero picks channel 0 at reset, one picks channel 1.
// - No conversion runs while the converter enable bit is clear.
// - Reference start counts measurement up from preset, time base up.
// - Any counter wrap during reference clears its start bit and stops.
// - Measurement wrap ending reference sets the reference done flag.
// - Time base wrap ending reference sets the time base overflow flag.
// - Sensor start counts measurement up, time base down from preset.
// - Time base zero or measurement wrap stops sensor, clearing start.
// - Time base zero sets the done flag of the started sensor.
// - Measurement wrap ending sensor sets measurement overflow flag.
// - Writing zero to running start bit aborts; counters hold values.
// - External clock input uses the same start, count and stop sequence.
// - One shared interrupt request line carries all five causes.
// - Each cause has a mask bit, clear at reset, gating the request.
// - Request rises in the same cycle its enabled flag is set.
// - Flags clear by writing one and stay set until cleared.
// - Continuous oscillation enable suppresses all automatic stops.
// - Time base counts the count clock only while its enable is one.
`timescale 1ns/100ps
`default_nettype none
`include "rfcs_defs.vh"
module rfcs_top #(
  parameter CW = 24
) (
  input  wire          CLK,
  input  wire          RST_B,
  input  wire [7:0]    ADDR,
  input  wire [31:0]   WDATA,
  input  wire          WR,
  input  wire          RD,
  output reg  [31:0]   RDATA,
  input  wire          CR_OSCILLATION_CLOCK,
  input  wire          EXT_INPUT_CLOCK,
  input  wire          COUNT_CLOCK,
  output reg           CH0_REF_OSC_EN,
  output reg           CH0_SEN_A_OSC_EN,
  output reg           CH0_SEN_B_OSC_EN,
  output reg           CH1_REF_OSC_EN,
  output reg           CH1_SEN_A_OSC_EN,
  output reg           CH1_SEN_B_OSC_EN,
  output reg  [1:0]    OSCILLATION_MODE_SELECT,
  output reg           INTERRUPT_REQUEST
);
  // ========================================================================
  // Register state
  reg [7:0]    ctl_r;
  reg          clk_en_r;
  reg [2:0]    trg_r;
  reg [2:0]    trg_nxt;
  reg [4:0]    imsk_r;
  reg [4:0]    iflg_r;
  reg [4:0]    iflg_nxt;
  wire [CW-1:0] mc_val;
  wire [CW-1:0] tc_val;

  wire converter_enable    = ctl_r[`RFCS_CTL_EN];
  wire channel_select      = ctl_r[`RFCS_CTL_CHANNEL_SELECT];
  wire event_mode          = ctl_r[`RFCS_CTL_EXT];
  wire continuous_osc_en   = ctl_r[`RFCS_CTL_CONT];

  wire wr_ctl  = WR & (ADDR == `RFCS_ADDR_CTL);
  wire wr_trg  = WR & (ADDR == `RFCS_ADDR_TRG);
  wire wr_mc   = WR & (ADDR == `RFCS_ADDR_MC);
  wire wr_tc   = WR & (ADDR == `RFCS_ADDR_TC);
  wire wr_imsk = WR & (ADDR == `RFCS_ADDR_IMSK);
  wire wr_iflg = WR & (ADDR == `RFCS_ADDR_IFLG);
  wire wr_clk  = WR & (ADDR == `RFCS_ADDR_CLK);

  // ========================================================================
  // Count clock edges
  wire src_clk = event_mode ? EXT_INPUT_CLOCK : CR_OSCILLATION_CLOCK;
  wire src_rise;
  wire count_clock_rise;
  rfcs_edge u_mc_edge (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (src_clk),
    .rise  (src_rise)
  );
  rfcs_edge u_tc_edge (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (COUNT_CLOCK),
    .rise  (count_clock_rise)
  );

  // ========================================================================
  // Sequencing
  wire ref_run    = trg_r[`RFCS_TRG_REF];
  wire sen_a_run  = trg_r[`RFCS_TRG_SA];
  wire sen_b_run  = trg_r[`RFCS_TRG_SB];
  wire sen_run    = sen_a_run | sen_b_run;
  wire running    = (ref_run | sen_run) & converter_enable;
  wire mc_step    = running & src_rise;
  wire tc_step    = running & count_clock_rise & clk_en_r;
  wire tc_down    = sen_run;
  wire mc_wrap;
  wire tc_wrap;
  wire tc_zero;

  rfcs_cnt #(.W(CW)) u_mc (
    .clk      (CLK),
    .rst_b    (RST_B),
    .load     (wr_mc),
    .load_val (WDATA[CW-1:0]),
    .step     (mc_step),
    .down     (1'b0),
    .cnt_r    (mc_val),
    .wrap     (mc_wrap),
    .hit_zero ()
  );
  rfcs_cnt #(.W(CW)) u_tc (
    .clk      (CLK),
    .rst_b    (RST_B),
    .load     (wr_tc),
    .load_val (WDATA[CW-1:0]),
    .step     (tc_step),
    .down     (tc_down),
    .cnt_r    (tc_val),
    .wrap     (tc_wrap),
    .hit_zero (tc_zero)
  );

  // Automatic stop events, none while continuous mode is on
  wire auto_ok    = ~continuous_osc_en;
  wire ref_mc_end = ref_run & mc_wrap & auto_ok;
  wire ref_tc_end = ref_run & tc_wrap & auto_ok;
  wire sen_tc_end = sen_run & tc_zero & auto_ok;
  wire sen_mc_end = sen_run & mc_wrap & auto_ok;
  wire stop_ev    = ref_mc_end | ref_tc_end | sen_tc_end | sen_mc_end;

  always @* begin
    trg_nxt = trg_r;
    if (wr_trg) begin
      // One start bit at a time, priority to the reference
      if (WDATA[`RFCS_TRG_REF]) begin
        trg_nxt = 3'h1;
      end else if (WDATA[`RFCS_TRG_SA]) begin
        trg_nxt = 3'h2;
      end else if (WDATA[`RFCS_TRG_SB]) begin
        trg_nxt = 3'h4;
      end else begin
        trg_nxt = 3'h0;
      end
    end
    if (stop_ev) begin
      trg_nxt = 3'h0;
    end
    if (!converter_enable) begin
      trg_nxt = 3'h0;
    end
  end

  // ========================================================================
  // Flags: hardware set wins over a write-one clear
  wire [4:0] flag_set;
  assign flag_set[`RFCS_IF_REF]  = ref_mc_end;
  assign flag_set[`RFCS_IF_SA]   = sen_tc_end & sen_a_run;
  assign flag_set[`RFCS_IF_SB]   = sen_tc_end & sen_b_run;
  assign flag_set[`RFCS_IF_OVMC] = sen_mc_end;
  assign flag_set[`RFCS_IF_OVTC] = ref_tc_end;
  wire [4:0] flag_clr = wr_iflg ? WDATA[4:0] : 5'h00;

  always @* begin
    iflg_nxt = (iflg_r & ~flag_clr) | flag_set;
  end

  // ========================================================================
  // Registers
  always @(posedge CLK) begin
    if (!RST_B) begin
      ctl_r    <= `RFCS_RST_CTL;
      clk_en_r <= 1'b0;
      trg_r    <= 3'h0;
      imsk_r   <= `RFCS_RST_MASK;
      iflg_r   <= 5'h00;
    end else begin
      if (wr_ctl) begin
        ctl_r <= {WDATA[7:4], 2'b00, WDATA[1:0]};
      end
      if (wr_clk) begin
        clk_en_r <= WDATA[`RFCS_CLK_EN];
      end
      if (wr_imsk) begin
        imsk_r <= WDATA[4:0];
      end
      trg_r  <= trg_nxt;
      iflg_r <= iflg_nxt;
    end
  end

  // ========================================================================
  // Oscillator enables and interrupt
  wire ref_nxt = trg_nxt[`RFCS_TRG_REF];
  wire sa_nxt  = trg_nxt[`RFCS_TRG_SA];
  wire sb_nxt  = trg_nxt[`RFCS_TRG_SB];
  wire ch_nxt  = wr_ctl ? WDATA[`RFCS_CTL_CHANNEL_SELECT] : channel_select;
  wire irq_nxt = |(iflg_nxt & imsk_r);

  always @(posedge CLK) begin
    if (!RST_B) begin
      CH0_REF_OSC_EN          <= 1'b0;
      CH0_SEN_A_OSC_EN        <= 1'b0;
      CH0_SEN_B_OSC_EN        <= 1'b0;
      CH1_REF_OSC_EN          <= 1'b0;
      CH1_SEN_A_OSC_EN        <= 1'b0;
      CH1_SEN_B_OSC_EN        <= 1'b0;
      OSCILLATION_MODE_SELECT <= 2'h0;
      INTERRUPT_REQUEST       <= 1'b0;
    end else begin
      CH0_REF_OSC_EN          <= ref_nxt & ~ch_nxt;
      CH0_SEN_A_OSC_EN        <= sa_nxt & ~ch_nxt;
      CH0_SEN_B_OSC_EN        <= sb_nxt & ~ch_nxt;
      CH1_REF_OSC_EN          <= ref_nxt & ch_nxt;
      CH1_SEN_A_OSC_EN        <= sa_nxt & ch_nxt;
      CH1_SEN_B_OSC_EN        <= sb_nxt & ch_nxt;
      OSCILLATION_MODE_SELECT <= wr_ctl ? WDATA[5:4] :
                                 ctl_r[`RFCS_CTL_MODE_H:`RFCS_CTL_MODE_L];
      INTERRUPT_REQUEST       <= irq_nxt;
    end
  end

  // ========================================================================
  // Read port, unmapped reads return zero
  always @(posedge CLK) begin
    if (!RST_B) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        `RFCS_ADDR_CTL:  RDATA <= {24'h000000, ctl_r};
        `RFCS_ADDR_TRG:  RDATA <= {29'h00000000, trg_r};
        `RFCS_ADDR_MC:   RDATA <= {8'h00, mc_val};
        `RFCS_ADDR_TC:   RDATA <= {8'h00, tc_val};
        `RFCS_ADDR_IMSK: RDATA <= {27'h0000000, imsk_r};
        `RFCS_ADDR_IFLG: RDATA <= {27'h0000000, iflg_r};
        `RFCS_ADDR_CLK:  RDATA <= {31'h00000000, clk_en_r};
        default:         RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule // rfcs_top
`default_nettype wire

// >>> tb/rfcs_osc_model.sv
// Purpose: CR oscillator stand-in driving the measurement clock
// Assumes: Any enabled oscillator runs at one fixed rate
// Notes:   Clock stands low while every oscillator is off
`timescale 1ns/100ps
`default_nettype none
module rfcs_osc_model #(
  parameter HALF = 3
) (
  input  wire       clk,
  input  wire [5:0] en,
  output reg        cr_clk
);
  integer cnt_r;
  initial begin
    cr_clk = 1'b0;
    cnt_r  = 0;
  end
  always @(posedge clk) begin
    if (en == 6'h00) begin
      cr_clk <= 1'b0;
      cnt_r  <= 0;
    end else if (cnt_r == HALF - 1) begin
      cr_clk <= ~cr_clk;
      cnt_r  <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule // rfcs_osc_model
`default_nettype wire

// >>> tb/rfcs_chk_asserts.sv
// Purpose: Port-level assertions for the converter sequencer
// Assumes: Register writes are the only source of control state
// Notes:   Shadows enable, channel, continuous and mask bits
`timescale 1ns/100ps
`default_nettype none
`include "rfcs_defs.vh"
module rfcs_chk (
  input wire        CLK,
  input wire        RST_B,
  input wire [7:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        CH0_REF_OSC_EN,
  input wire        CH0_SEN_A_OSC_EN,
  input wire        CH0_SEN_B_OSC_EN,
  input wire        CH1_REF_OSC_EN,
  input wire        CH1_SEN_A_OSC_EN,
  input wire        CH1_SEN_B_OSC_EN,
  input wire        INTERRUPT_REQUEST
);
  // ==========
  // Shadow state
  wire [5:0] osc = {CH1_SEN_B_OSC_EN, CH1_SEN_A_OSC_EN, CH1_REF_OSC_EN,
                    CH0_SEN_B_OSC_EN, CH0_SEN_A_OSC_EN, CH0_REF_OSC_EN};
  wire       trg_w = WR && ADDR == `RFCS_ADDR_TRG;
  reg        en_r;
  reg        ch_r;
  reg        cont_r;
  reg  [4:0] mask_r;
  always @(posedge CLK) begin
    if (!RST_B) begin
      en_r   <= 1'b0;
      ch_r   <= 1'b0;
      cont_r <= 1'b0;
      mask_r <= 5'h00;
    end else begin
      if (WR && ADDR == `RFCS_ADDR_CTL) begin
        en_r   <= WDATA[0];
        ch_r   <= WDATA[1];
        cont_r <= WDATA[7];
      end
      if (WR && ADDR == `RFCS_ADDR_IMSK)
        mask_r <= WDATA[4:0];
    end
  end
  // ==========
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  one_osc_a: assert property ($onehot0(osc))
    else $error("more than one oscillator on");
  chan_sel_a: assert property (|osc |-> (ch_r ? !(|osc[2:0]) : !(|osc[5:3])))
    else $error("wrong channel oscillating");
  off_a: assert property (!en_r && !$past(en_r) |-> osc == 6'h00)
    else $error("oscillation while disabled");
  abort_a: assert property (trg_w && WDATA[2:0] == 3'h0 |=> osc == 6'h00)
    else $error("abort did not stop");
  ref_go_a: assert property (trg_w && WDATA[0] && en_r |=> osc[0] || osc[3])
    else $error("reference did not start");
  sen_go_a: assert property (trg_w && WDATA[2:0] == 3'h2 && en_r |=> osc[1] || osc[4])
    else $error("sensor A did not start");
  mask_a: assert property (mask_r == 5'h00 && $past(mask_r) == 5'h00 |-> !INTERRUPT_REQUEST)
    else $error("request with all causes masked");
  irq_stop_a: assert property ($fell(|osc) && !$past(WR) && mask_r == 5'h1f |-> INTERRUPT_REQUEST)
    else $error("no request at automatic stop");
  irq_hold_a: assert property (INTERRUPT_REQUEST && !(WR && ADDR[7:1] == 7'h02) |=> INTERRUPT_REQUEST)
    else $error("request dropped without a clear");
  cont_run_a: assert property (cont_r && |osc && !WR |=> osc == $past(osc))
    else $error("continuous oscillation stopped");
endmodule // rfcs_chk
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Oscillator model drives the CR clock
// Notes:   Count clock rises every 16 cycles
`timescale 1ns/100ps
`default_nettype none
module tb;
  reg         clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  reg         ext = 1'b0, cnt_clk = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0, v, a, seed = 32'h9d21a116;
  wire [31:0] rdata;
  wire [5:0]  osc;
  wire [1:0]  mode;
  wire        irq, cr_clk;
  integer     num_errors = 0, checks = 0, cyc = 0, i;
  // ==========
  // Clock, stimulus and design
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ext <= $random(seed);
    if (cyc[2:0] == 3'h0) cnt_clk <= ~cnt_clk;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  rfcs_top dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CR_OSCILLATION_CLOCK(cr_clk),
    .EXT_INPUT_CLOCK(ext), .COUNT_CLOCK(cnt_clk),
    .CH0_REF_OSC_EN(osc[0]), .CH0_SEN_A_OSC_EN(osc[1]),
    .CH0_SEN_B_OSC_EN(osc[2]), .CH1_REF_OSC_EN(osc[3]),
    .CH1_SEN_A_OSC_EN(osc[4]), .CH1_SEN_B_OSC_EN(osc[5]),
    .OSCILLATION_MODE_SELECT(mode), .INTERRUPT_REQUEST(irq));
  rfcs_osc_model u_osc (.clk(clk), .en(osc), .cr_clk(cr_clk));
  // ==========
  // Tasks
  task bus_wr(input [7:0] ad, input [31:0] d);
    begin
      @(posedge clk);
      addr  <= ad;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task bus_rd(input [7:0] ad, output [31:0] d);
    begin
      @(posedge clk);
      addr <= ad;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [31:0] fexp(input [2:0] g, input w);
    fexp = g[0] ? (w ? 32'h1 : 32'h10) : (w ? 32'h8 : {29'h0, g});
  endfunction
  function [31:0] rnd(input [23:0] b);
    rnd = {8'h0, b + 24'({$random(seed)} % 16)};
  endfunction
  task conv(input [31:0] c, m, t, input [2:0] g, input [4:0] mk, input w);
    begin
      bus_wr(8'h00, c);
      bus_wr(8'h06, 32'h1);
      bus_wr(8'h02, m);
      bus_wr(8'h03, t);
      bus_wr(8'h05, 32'h1f);
      bus_wr(8'h04, {27'h0, mk});
      bus_wr(8'h01, {29'h0, g});
      #1 chk({26'h0, osc}, c[1] ? {26'h0, g, 3'h0} : {29'h0, g});
      i = 0;
      while (osc !== 6'h00 && i < 3000) begin
        @(posedge clk);
        #1 i = i + 1;
      end
      if (i >= 3000) num_errors = num_errors + 1;
      bus_rd(8'h05, v);
      chk(v, fexp(g, w));
      bus_rd(8'h01, v);
      chk(v, 32'h0);
      chk({31'h0, irq}, {31'h0, |(fexp(g, w) & mk)});
      chk({30'h0, mode}, {30'h0, c[5:4]});
      $display("conv ctl=%h trg=%h done", c, g);
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    bus_rd(8'h00, v);
    chk(v, 32'h0);
    bus_rd(8'h04, v);
    chk(v, 32'h0);
    conv(32'h01, rnd(24'hffffec), 32'h0, 3'h1, 5'h1f, 1'b1);
    conv(32'h03, 32'h0, rnd(24'hffffec), 3'h1, 5'h1f, 1'b0);
    conv(32'h11, 32'h0, rnd(24'h4), 3'h2, 5'h1f, 1'b0);
    conv(32'h23, 32'h0, rnd(24'h4), 3'h4, 5'h1f, 1'b0);
    conv(32'h01, rnd(24'hffffec), 32'hffff, 3'h4, 5'h1f, 1'b1);
    conv(32'h41, rnd(24'hffffec), 32'h0, 3'h1, 5'h1f, 1'b1);
    conv(32'h01, 32'h0, rnd(24'h4), 3'h2, 5'h00, 1'b0);
    bus_wr(8'h04, 32'h1f);
    bus_rd(8'h05, v);
    chk({31'h0, irq}, 32'h1);
    bus_wr(8'h05, 32'h0);
    bus_rd(8'h05, v);
    chk(v, 32'h2);
    bus_wr(8'h05, 32'h1f);
    bus_rd(8'h05, v);
    chk({v[30:0], irq}, 32'h0);
    bus_wr(8'h02, 32'h0);
    bus_wr(8'h01, 32'h1);
    repeat (40) @(posedge clk);
    bus_wr(8'h01, 32'h0);
    bus_rd(8'h02, a);
    repeat (40) @(posedge clk);
    bus_rd(8'h02, v);
    chk(v, a);
    chk({25'h0, osc, a != 32'h0}, 32'h1);
    bus_wr(8'h00, 32'h0);
    bus_wr(8'h01, 32'h1);
    bus_rd(8'h01, v);
    chk({v[25:0], osc}, 32'h0);
    bus_wr(8'h00, 32'h81);
    bus_wr(8'h02, 32'hfffffe);
    bus_wr(8'h01, 32'h1);
    repeat (100) @(posedge clk);
    bus_rd(8'h05, v);
    chk({v[25:0], osc}, 32'h1);
    bus_wr(8'h01, 32'h0);
    bus_wr(8'h00, 32'h01);
    bus_wr(8'h06, 32'h0);
    bus_wr(8'h02, 32'h0);
    bus_wr(8'h03, 32'h0);
    bus_wr(8'h01, 32'h1);
    repeat (100) @(posedge clk);
    bus_rd(8'h03, v);
    chk(v, 32'h0);
    bus_wr(8'h01, 32'h0);
    bus_wr(8'h06, 32'h1);
    $display("abort, disable, continuous and clock gate tests done");
    final_report;
  end
endmodule // tb
bind rfcs_top rfcs_chk u_chk (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .CH0_REF_OSC_EN(CH0_REF_OSC_EN),
  .CH0_SEN_A_OSC_EN(CH0_SEN_A_OSC_EN), .CH0_SEN_B_OSC_EN(CH0_SEN_B_OSC_EN),
  .CH1_REF_OSC_EN(CH1_REF_OSC_EN), .CH1_SEN_A_OSC_EN(CH1_SEN_A_OSC_EN),
  .CH1_SEN_B_OSC_EN(CH1_SEN_B_OSC_EN),
  .INTERRUPT_REQUEST(INTERRUPT_REQUEST));
`default_nettype wire
